// File: rtl/rsld_top.sv
// Behaviour
// - A steady when local A, partner B
// - B steady when local B, partner A
// - both A: A blinks, B off
// - both B: B blinks, A off
// - local Clear: A and B blink
// - A off unless local A or Clear
// - B off unless local B or Clear
// - partner run: on, blink stopped, off lost
// - primary: on primary, blink wait, else off
// - backup steady in standby, off in no role or as primary with standby partner
// - backup blinks: primary lone, or waiting
// - running, both blinking means wait role
// - primary with waiting partner: on, blink
// - link steady while communicating
// - link blinks: ready, no link made
// - link off: unconfigured or not operational
`timescale 1ns/100ps
`default_nettype none
module rsld_top
   import rsld_pkg::*;
#(
   parameter int BLINK_HALF_CYC = BLINK_HALF_CYC_DEF,
   parameter rsld_wait_t WAIT_PATTERN = WAIT_BOTH_BLINK
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   output logic o_led_unit_a,
   output logic o_led_unit_b,
   output logic o_led_remote_run,
   output logic o_led_primary,
   output logic o_led_backup,
   output logic o_led_link
);

   // ****************************************************
   // blink source
   // ****************************************************
   rsld_blink_if blink_bus ();

   rsld_blink #(
      .HALF_CYC(BLINK_HALF_CYC)
   ) u_blink (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .bl(blink_bus.src)
   );

   // ****************************************************
   // bus slave
   // ****************************************************
   logic [ST_WIDTH-1:0] state;
   logic [ST_WIDTH-1:0] next_state;
   logic enable;
   logic next_enable;
   logic dp_write;
   logic [11:0] dp_addr;
   logic ap_valid;
   logic [11:0] ap_addr;
   logic [31:0] leds_word;

   assign ap_valid = i_hsel && i_hready &&
      (i_htrans == HTRANS_NONSEQ || i_htrans == HTRANS_SEQ);
   assign ap_addr = {i_haddr[11:ADDR_LSB], 2'h0};
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   // pending write lands in the same edge a following read samples
   always_comb begin
      next_state = state;
      next_enable = enable;
      if (dp_write && dp_addr == OFF_STATE) begin
         next_state = i_hwdata[ST_WIDTH-1:0];
      end
      if (dp_write && dp_addr == OFF_CTRL) begin
         next_enable = i_hwdata[CT_ENABLE];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         dp_write <= 1'b0;
         dp_addr <= 12'h000;
      end else begin
         dp_write <= ap_valid && i_hwrite;
         dp_addr <= ap_addr;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         state <= RST_STATE[ST_WIDTH-1:0];
         enable <= RST_CTRL[CT_ENABLE];
      end else begin
         state <= next_state;
         enable <= next_enable;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_hrdata <= 32'h0000_0000;
      end else if (ap_valid && !i_hwrite) begin
         case (ap_addr)
            OFF_STATE: o_hrdata <= {18'h00000, next_state};
            OFF_LEDS: o_hrdata <= leds_word;
            OFF_CTRL: o_hrdata <= {31'h0000_0000, next_enable};
            default: o_hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************
   // state fields
   // ****************************************************
   rsld_sel_t loc_sel;
   rsld_sel_t rem_sel;
   rsld_role_t loc_role;
   rsld_role_t rem_role;
   logic loc_run;
   logic rem_run;
   logic remote_io_up;
   logic lnk_cfg;
   logic lnk_oper;
   logic lnk_comm;

   assign loc_sel = state[ST_LOC_SEL +: 2];
   assign rem_sel = state[ST_REM_SEL +: 2];
   assign loc_role = state[ST_LOC_ROLE +: 2];
   assign rem_role = state[ST_REM_ROLE +: 2];
   assign loc_run = state[ST_LOC_RUN];
   assign rem_run = state[ST_REM_RUN];
   assign remote_io_up = state[ST_REMOTE_IO];
   assign lnk_cfg = state[ST_LNK_CFG];
   assign lnk_oper = state[ST_LNK_OPER];
   assign lnk_comm = state[ST_LNK_COMM];

   // ****************************************************
   // unit selection decode
   // ****************************************************
   function automatic rsld_pat_t unit_pat(input rsld_sel_t loc,
                                          input rsld_sel_t rem,
                                          input rsld_sel_t mine,
                                          input rsld_sel_t other);
      rsld_pat_t p;
      p = PAT_OFF;
      if (loc == SEL_CLEAR) begin
         p = PAT_BLINK;
      end else if (loc == mine && rem == other) begin
         p = PAT_ON;
      end else if (loc == mine && rem == mine) begin
         p = PAT_BLINK;
      end else begin
         p = PAT_OFF;
      end
      return p;
   endfunction

   rsld_pat_t pat_a;
   rsld_pat_t pat_b;
   rsld_pat_t pat_rrun;
   rsld_pat_t pat_primary_role_indicator;
   rsld_pat_t pat_back;
   rsld_pat_t pat_link;

   assign pat_a = unit_pat(loc_sel, rem_sel, SEL_A, SEL_B);
   assign pat_b = unit_pat(loc_sel, rem_sel, SEL_B, SEL_A);

   // ****************************************************
   // partner run and link decode
   // ****************************************************
   always_comb begin
      if (!lnk_comm && !remote_io_up) begin
         pat_rrun = PAT_OFF;
      end else if (rem_run) begin
         pat_rrun = PAT_ON;
      end else begin
         pat_rrun = PAT_BLINK;
      end
   end

   always_comb begin
      if (!lnk_cfg || !lnk_oper) begin
         pat_link = PAT_OFF;
      end else if (lnk_comm) begin
         pat_link = PAT_ON;
      end else begin
         pat_link = PAT_BLINK;
      end
   end

   // ****************************************************
   // role decode
   // ****************************************************
   always_comb begin
      pat_primary_role_indicator = PAT_OFF;
      pat_back = PAT_OFF;
      case (loc_role)
         ROLE_PRIMARY: begin
            pat_primary_role_indicator = PAT_ON;
            if (rem_role != ROLE_STANDBY) begin
               pat_back = PAT_BLINK;
            end
         end
         ROLE_STANDBY: begin
            pat_back = PAT_ON;
         end
         ROLE_WAIT: begin
            if (!loc_run || WAIT_PATTERN == WAIT_BOTH_BLINK) begin
               pat_primary_role_indicator = PAT_BLINK;
               pat_back = PAT_BLINK;
            end else if (WAIT_PATTERN == WAIT_BACKUP_BLINK) begin
               pat_back = PAT_BLINK;
            end else begin
               pat_primary_role_indicator = PAT_OFF;
               pat_back = PAT_OFF;
            end
         end
         default: begin
            pat_primary_role_indicator = PAT_OFF;
            pat_back = PAT_OFF;
         end
      endcase
   end

   assign leds_word = {19'h00000, blink_bus.phase, pat_link, pat_back,
                       pat_primary_role_indicator, pat_rrun, pat_b, pat_a};

   // ****************************************************
   // lamp drive
   // ****************************************************
   function automatic logic lamp(input rsld_pat_t p, input logic ph,
                                 input logic en);
      return en && (p == PAT_ON || (p == PAT_BLINK && ph));
   endfunction

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_led_unit_a <= 1'b0;
         o_led_unit_b <= 1'b0;
         o_led_remote_run <= 1'b0;
         o_led_primary <= 1'b0;
         o_led_backup <= 1'b0;
         o_led_link <= 1'b0;
      end else begin
         o_led_unit_a <= lamp(pat_a, blink_bus.phase, enable);
         o_led_unit_b <= lamp(pat_b, blink_bus.phase, enable);
         o_led_remote_run <= lamp(pat_rrun, blink_bus.phase, enable);
         o_led_primary <= lamp(pat_primary_role_indicator, blink_bus.phase, enable);
         o_led_backup <= lamp(pat_back, blink_bus.phase, enable);
         o_led_link <= lamp(pat_link, blink_bus.phase, enable);
      end
   end

endmodule
`default_nettype wire

// File: rtl/rsld_pkg.sv
`default_nettype none
package rsld_pkg;

   // ****************************************************
   // bus and register map
   // ****************************************************
   localparam int ADDR_LSB = 2;
   localparam logic [11:0] OFF_STATE = 12'h000;
   localparam logic [11:0] OFF_LEDS = 12'h004;
   localparam logic [11:0] OFF_CTRL = 12'h008;
   localparam logic [31:0] RST_STATE = 32'h0000_0fff;
   localparam logic [31:0] RST_CTRL = 32'h0000_0001;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   // ****************************************************
   // state register fields
   // ****************************************************
   localparam int ST_LOC_SEL = 0;
   localparam int ST_REM_SEL = 2;
   localparam int ST_LOC_ROLE = 4;
   localparam int ST_REM_ROLE = 6;
   localparam int ST_LOC_RUN = 8;
   localparam int ST_REM_RUN = 9;
   localparam int ST_REMOTE_IO = 10;
   localparam int ST_LNK_CFG = 11;
   localparam int ST_LNK_OPER = 12;
   localparam int ST_LNK_COMM = 13;
   localparam int ST_WIDTH = 14;

   // ****************************************************
   // indicator status fields and control fields
   // ****************************************************
   localparam int LS_UNIT_A = 0;
   localparam int LS_UNIT_B = 2;
   localparam int LS_REM_RUN = 4;
   localparam int LS_PRIMARY = 6;
   localparam int LS_BACKUP = 8;
   localparam int LS_LINK = 10;
   localparam int LS_PHASE = 12;
   localparam int CT_ENABLE = 0;

   // ****************************************************
   // codes
   // ****************************************************
   typedef logic [1:0] rsld_pat_t;
   localparam rsld_pat_t PAT_OFF = 2'h0;
   localparam rsld_pat_t PAT_ON = 2'h1;
   localparam rsld_pat_t PAT_BLINK = 2'h2;

   typedef logic [1:0] rsld_sel_t;
   localparam rsld_sel_t SEL_A = 2'h0;
   localparam rsld_sel_t SEL_B = 2'h1;
   localparam rsld_sel_t SEL_CLEAR = 2'h2;

   typedef logic [1:0] rsld_role_t;
   localparam rsld_role_t ROLE_PRIMARY = 2'h0;
   localparam rsld_role_t ROLE_STANDBY = 2'h1;
   localparam rsld_role_t ROLE_WAIT = 2'h2;
   localparam rsld_role_t ROLE_NONE = 2'h3;

   typedef enum {
      WAIT_BOTH_BLINK,
      WAIT_BOTH_OFF,
      WAIT_BACKUP_BLINK
   } rsld_wait_t;

   // ****************************************************
   // timing
   // ****************************************************
   localparam int CLK_HZ = 25_000_000;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_HALF_CYC_DEF = (CLK_HZ / 1000) * BLINK_HALF_MS;

endpackage
`default_nettype wire

// File: rtl/rsld_blink_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rsld_blink_if;
   logic phase;
   modport src (output phase);
   modport dst (input phase);
endinterface
`default_nettype wire

// File: rtl/rsld_blink.sv
`timescale 1ns/100ps
`default_nettype none
module rsld_blink
   import rsld_pkg::*;
#(
   parameter int HALF_CYC = BLINK_HALF_CYC_DEF
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   rsld_blink_if.src bl
);

   logic [31:0] count;
   logic wrap;

   assign wrap = (count == 32'(HALF_CYC - 1));

   // ****************************************************
   // shared free-running divider
   // ****************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         count <= 32'h0000_0000;
      end else if (wrap) begin
         count <= 32'h0000_0000;
      end else begin
         count <= count + 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         bl.phase <= 1'b0;
      end else begin
         if (wrap) begin
            bl.phase <= ~bl.phase;
         end
      end
   end

endmodule
`default_nettype wire

// File: sim/rsld_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module rsld_top_monitor
   import rsld_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic o_led_unit_a,
   input wire logic o_led_unit_b,
   input wire logic o_led_remote_run,
   input wire logic o_led_primary,
   input wire logic o_led_backup,
   input wire logic o_led_link
);
   logic [13:0] st;
   logic en;
   logic wp;
   logic [9:0] wa;
   logic [1:0] quiet;
   logic ok;
   // ****************************************************
   // shadow of the written registers
   // ****************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st <= RST_STATE[13:0];
         en <= 1'b1;
         wp <= 1'b0;
         quiet <= 2'h0;
      end else begin
         wp <= i_hsel & i_hready & i_htrans[1] & i_hwrite;
         if (wp && wa == OFF_STATE[11:2]) begin
            st <= i_hwdata[13:0];
         end
         if (wp && wa == OFF_CTRL[11:2]) begin
            en <= i_hwdata[0];
         end
         if (wp) begin
            quiet <= 2'h0;
         end else if (quiet != 2'h3) begin
            quiet <= quiet + 2'h1;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      wa <= i_haddr[11:2];
   end
   assign ok = en && quiet == 2'h3;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   unit_a_on_a:
      assert property (ok && st[3:0] == 4'h4 |-> o_led_unit_a) else $error("a");
   unit_b_on_a:
      assert property (ok && st[3:0] == 4'h1 |-> o_led_unit_b) else $error("b");
   both_a_b_a:
      assert property (ok && st[3:0] == 4'h0 |-> !o_led_unit_b) else $error("ab");
   clear_pair_a:
      assert property (ok && st[1:0] == 2'h2 |-> o_led_unit_a == o_led_unit_b)
         else $error("clear");
   unit_a_off_a:
      assert property (quiet == 2'h3 && st[1:0] inside {2'h1, 2'h3}
         |-> !o_led_unit_a) else $error("a off");
   unit_b_off_a:
      assert property (quiet == 2'h3 && st[1:0] inside {2'h0, 2'h3}
         |-> !o_led_unit_b) else $error("b off");
   remote_lost_a:
      assert property (quiet == 2'h3 && !st[13] && !st[10]
         |-> !o_led_remote_run) else $error("remote");
   backup_on_a:
      assert property (ok && st[5:4] == 2'h1 |-> o_led_backup && !o_led_primary)
         else $error("backup");
   link_on_a:
      assert property (ok && st[13:11] == 3'h7 |-> o_led_link)
         else $error("link on");
   link_off_a:
      assert property (quiet == 2'h3 && !(st[11] && st[12])
         |-> !o_led_link) else $error("link off");
   blink_phase_a:
      assert property (ok && st[1:0] == 2'h2 && st[13:11] == 3'h3
         |-> o_led_link == o_led_unit_a) else $error("phase");
   bus_okay_a:
      assert property (o_hreadyout && !o_hresp) else $error("bus resp");
   cover property (ok && st[1:0] == 2'h2 && o_led_unit_a);
   cover property (ok && st[13:11] == 3'h3 && o_led_link);
   cover property (ok && st[5:4] == 2'h1);
endmodule
bind rsld_top rsld_top_monitor i_mon (.i_clk(i_clk), .i_rstn(i_rstn),
   .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .o_led_unit_a(o_led_unit_a), .o_led_unit_b(o_led_unit_b),
   .o_led_remote_run(o_led_remote_run), .o_led_primary(o_led_primary),
   .o_led_backup(o_led_backup), .o_led_link(o_led_link));
`default_nettype wire

// File: sim/rsld_lamp_view.sv
`timescale 1ns/100ps
`default_nettype none
module rsld_lamp_view (
   input wire logic i_clk,
   input wire logic i_clr,
   input wire logic [5:0] i_lamp,
   output logic [5:0] o_moved
);
   logic [5:0] last;
   // operator notices any lamp that changed since clear
   always_ff @(posedge i_clk) begin
      last <= i_lamp;
      o_moved <= i_clr ? 6'h00 : o_moved | (last ^ i_lamp);
   end
endmodule
`default_nettype wire

// File: sim/rsld_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module rsld_top_test;
   import rsld_pkg::*;
   logic clk, rstn, hsel, hwrite, hrdy, clr;
   logic [31:0] haddr, hwdata, hrdata, q, r;
   logic [1:0] htrans;
   logic [5:0] lamp, moved;
   logic [11:0] p;
   logic [13:0] s;
   int bad_count, n_compared, seed;
   rsld_top #(.BLINK_HALF_CYC(4)) i_rsld_top (.i_clk(clk), .i_rstn(rstn),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
      .o_hreadyout(hrdy), .o_hresp(), .o_hrdata(hrdata),
      .o_led_unit_a(lamp[0]), .o_led_unit_b(lamp[1]),
      .o_led_remote_run(lamp[2]), .o_led_primary(lamp[3]),
      .o_led_backup(lamp[4]), .o_led_link(lamp[5]));
   rsld_lamp_view i_rsld_lamp_view (.i_clk(clk), .i_clr(clr),
      .i_lamp(lamp), .o_moved(moved));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ****************************************************
   // reference decode, two bits per lamp
   // ****************************************************
   function automatic logic [11:0] pats(input logic [13:0] v);
      logic [1:0] a, b, rn, pr, bk, lk;
      a = v[1:0] == 2'h2 ? 2'h2 : v[1:0] != 2'h0 ? 2'h0 :
          v[3:2] == 2'h1 ? 2'h1 : v[3:2] == 2'h0 ? 2'h2 : 2'h0;
      b = v[1:0] == 2'h2 ? 2'h2 : v[1:0] != 2'h1 ? 2'h0 :
          v[3:2] == 2'h0 ? 2'h1 : v[3:2] == 2'h1 ? 2'h2 : 2'h0;
      rn = (v[13] | v[10]) ? (v[9] ? 2'h1 : 2'h2) : 2'h0;
      pr = v[5:4] == 2'h0 ? 2'h1 : v[5:4] == 2'h2 ? 2'h2 : 2'h0;
      bk = v[5:4] == 2'h1 ? 2'h1 : v[5:4] == 2'h2 ? 2'h2 :
           v[5:4] == 2'h0 && v[7:6] != 2'h1 ? 2'h2 : 2'h0;
      lk = !(v[11] & v[12]) ? 2'h0 : v[13] ? 2'h1 : 2'h2;
      return {lk, bk, pr, rn, b, a};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      n_compared++;
      if (v !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, v);
      end
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wt();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         q = hrdata;
         n++;
         if (n > 50) begin
            bad_count++;
            test_done();
         end
      end while (hrdy !== 1'b1);
      @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      wt();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      r = q;
   endtask
   initial begin
      seed = 32'h1d7dd59e;
      {rstn, hsel, hwrite, clr, htrans, haddr, hwdata} = '0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      bus(1'b0, OFF_STATE, 0);
      chk("state", RST_STATE, r);
      bus(1'b0, OFF_CTRL, 0);
      chk("ctrl", RST_CTRL, r);
      bus(1'b1, 12'h00c, 32'hffffffff);
      bus(1'b0, 12'h00c, 0);
      chk("unmapped", 0, r);
      $display("test reset done");
      for (int i = 0; i < 80; i++) begin
         s = 14'($random(seed));
         if (i < 16) s[3:0] = 4'(i);
         bus(1'b1, OFF_STATE, {$random(seed)} & 32'hffffc000 | s);
         bus(1'b1, OFF_CTRL, {31'h0, i % 8 != 7});
         bus(1'b1, OFF_LEDS, 32'h0);
         bus(1'b0, OFF_STATE, 0);
         chk("state", {18'h0, s}, r);
         bus(1'b0, OFF_LEDS, 0);
         p = pats(s);
         chk("leds", {20'h0, p}, {20'h0, r[11:0]});
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         repeat (24) @(posedge clk);
         @(negedge clk);
         for (int k = 0; k < 6; k++) begin
            chk("moved", {31'h0, i % 8 != 7 && p[2*k+:2] == 2'h2},
                {31'h0, moved[k]});
            if (p[2*k+:2] != 2'h2)
               chk("lamp", {31'h0, i % 8 != 7 && p[2*k+:2] == 2'h1},
                   {31'h0, lamp[k]});
         end
         @(posedge clk);
      end
      $display("test decode done");
      test_done();
   end
endmodule
`default_nettype wire
